// >>> design/i2c_exp_pkg.sv
// Shared constants for the expander bus front end and alert logic.
package i2c_exp_pkg;
	localparam int         GPIO_N        = 18;
	localparam logic [6:0] SLAVE_ADDR    = 7'h34;
	localparam logic       DIR_READ      = 1'b1;
	localparam int         CLK_NS        = 8;
	localparam int         GLITCH_NS     = 50;
	localparam int         GLITCH_CYC    = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam int         DEB_TICK_US   = 50;
	localparam int         DEB_TICK_CYC  = DEB_TICK_US * 1000 / CLK_NS;
	localparam int         RESET_HOLD_US = 120;
	localparam int         RESET_CYC     = RESET_HOLD_US * 1000 / CLK_NS;
	localparam logic [17:0] PULL_RST     = 18'h3ffff;
	localparam logic [17:0] ZERO18       = 18'h00000;
	localparam logic [3:0] BITS_BYTE     = 4'h8;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b010,
		ST_WBYT = 3'b011,
		ST_WACK = 3'b100,
		ST_RBYT = 3'b101,
		ST_RACK = 3'b110,
		ST_IGN  = 3'b111
	} bus_state_t;
endpackage

// >>> design/i2c_line_filter.sv
// Two-flop synchroniser followed by a spike filter for one bus line.
module i2c_line_filter (
	input  wire logic ref_clk,
	input  wire logic resetn,
	input  wire logic raw,
	output logic      filt
);
	logic       sync1;
	logic       sync2;
	logic [2:0] cnt;
	wire        differs = sync2 != filt;
	wire        settled = cnt == 3'(i2c_exp_pkg::GLITCH_CYC - 1);

	// Idle bus level is high, so the filter starts high to avoid a false start.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			cnt   <= 3'h0;
			filt  <= 1'b1;
		end
		else
		begin
			sync1 <= raw;
			sync2 <= sync1;
			cnt   <= (differs && !settled) ? cnt + 3'h1 : 3'h0;
			if (differs && settled)
				filt <= sync2;
		end
	end
endmodule

// >>> design/gpio_debounce.sv
// Input synchroniser with an optional two-stage tick-clocked debounce.
module gpio_debounce (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        tick,
	input  wire logic        bypass,
	input  wire logic [17:0] pin,
	output logic      [17:0] state
);
	logic [17:0] sync1;
	logic [17:0] sync2;
	logic [17:0] stage1;
	logic [17:0] stage2;
	logic [17:0] next_stage2;

	genvar i;
	generate
		for (i = 0; i < i2c_exp_pkg::GPIO_N; i++)
		begin : g_bit
			assign next_stage2[i] = (sync2[i] == stage1[i]) ? stage1[i] : stage2[i];
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1  <= i2c_exp_pkg::ZERO18;
			sync2  <= i2c_exp_pkg::ZERO18;
			stage1 <= i2c_exp_pkg::ZERO18;
			stage2 <= i2c_exp_pkg::ZERO18;
			state  <= i2c_exp_pkg::ZERO18;
		end
		else
		begin
			sync1 <= pin;
			sync2 <= sync1;
			if (tick)
			begin
				stage1 <= sync2;
				stage2 <= next_stage2;
			end
			state <= bypass ? sync2 : stage2;
		end
	end
endmodule

// >>> design/i2c_exp_core.sv
// Bus slave front end, reset handling and change-detect alert of the expander.

// Notes on behaviour
// - After reset every line is an input with its pulldown enabled.
// - A low reset pin forces all state and the bus machine to defaults.
// - Power-on reset and the reset pin have exactly the same effect.
// - The open-drain active-low alert tells the master an input changed.
// - Any edge on an input line raises a pending change, and the alert if its gpio_int_en bit is set.
// - Alert valid within 120 us with debounce, within 1 us without.
// - A pending change clears on return to old level or port read.
// - A read clear acts on the rising clock edge of the acknowledge bit.
// - The alert releases within 1 us after the clearing clock edge.
// - A change during the clearing acknowledge pulse may be lost.
// - After a clear every later change is detected and reported again.
// - Traffic to other slaves and output lines never touch the alert.
// - Turning an output into an input compares pin to stored value.
// - A start is data falling while the clock is high.
// - A stop is data rising while the clock is high; return to idle.
// - The address byte comes MSB first, direction bit last.
// - The slave address is 0110100; direction 1 reads, 0 writes.
// - A matching address is acknowledged by holding data low.
// - One bit per clock pulse; data stays stable while clock is high.
// - Bytes are eight bits plus an acknowledge; transmitter releases data.
// - Every received byte is acknowledged through the clock high phase.
// - On a not-acknowledge the device releases data for the stop.
module i2c_exp_core #(
	parameter int DEB_TICK_CYC = i2c_exp_pkg::DEB_TICK_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_n,
	input  wire logic        int_in,
	output logic             int_out,
	output logic             int_oe_n,
	input  wire logic [17:0] gpio_in,
	input  wire logic [17:0] gpio_dir,
	input  wire logic [17:0] gpio_int_en,
	input  wire logic        debounce_en,
	input  wire logic [17:0] read_sel_mask,
	input  wire logic [7:0]  tx_data,
	output logic [17:0]      pull_en,
	output logic [17:0]      input_state,
	output logic [17:0]      int_stat,
	output logic [7:0]       rx_data,
	output logic             rx_valid,
	output logic             rx_first,
	output logic             tx_load,
	output logic             bus_busy
);
	logic                     scl_f;
	logic                     sda_f;
	logic                     scl_q;
	logic                     sda_q;
	logic [17:0]              deb_val;
	logic [17:0]              ref_val;
	logic [12:0]              tick_cnt;
	logic                     tick;
	i2c_exp_pkg::bus_state_t  state;
	i2c_exp_pkg::bus_state_t  next_state;
	logic [3:0]               bit_cnt;
	logic [7:0]               shreg;
	logic                     pull_low;
	logic                     is_read;
	logic                     first_pend;
	logic                     rd_clr;
	logic                     int_sync1;
	logic                     int_sync2;

	i2c_line_filter u_scl (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.raw     (scl_in),
		.filt    (scl_f)
	);

	i2c_line_filter u_sda (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.raw     (sda_in),
		.filt    (sda_f)
	);

	gpio_debounce u_deb (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.tick    (tick),
		.bypass  (!debounce_en),
		.pin     (gpio_in),
		.state   (deb_val)
	);

	// Bus events taken from the filtered lines, and the debounce tick wrap.
	wire scl_rise  = scl_f && !scl_q;
	wire scl_fall  = !scl_f && scl_q;
	wire start_det = scl_f && scl_q && !sda_f && sda_q;
	wire stop_det  = scl_f && scl_q && sda_f && !sda_q;
	wire byte_done = bit_cnt == i2c_exp_pkg::BITS_BYTE;
	wire addr_hit  = shreg[7:1] == i2c_exp_pkg::SLAVE_ADDR;
	wire tick_wrap = tick_cnt == 13'(DEB_TICK_CYC - 1);

	// Change detection: outputs hold the stored value so a later switch to input compares.
	wire [17:0] is_input   = ~gpio_dir;
	wire [17:0] next_stat  = is_input & (deb_val ^ ref_val);
	wire [17:0] clr_bits   = rd_clr ? read_sel_mask : i2c_exp_pkg::ZERO18;
	wire [17:0] next_ref   = (ref_val & ~clr_bits) | (deb_val & clr_bits);
	wire        alert      = |(int_stat & gpio_int_en);

	always_comb
	begin
		next_state = state;
		case (state)
			i2c_exp_pkg::ST_IDLE: next_state = state;
			i2c_exp_pkg::ST_ADDR:
				if (scl_fall && byte_done)
					next_state = addr_hit ? i2c_exp_pkg::ST_AACK : i2c_exp_pkg::ST_IGN;
			i2c_exp_pkg::ST_AACK:
				if (scl_fall)
					next_state = is_read ? i2c_exp_pkg::ST_RBYT : i2c_exp_pkg::ST_WBYT;
			i2c_exp_pkg::ST_WBYT:
				if (scl_fall && byte_done)
					next_state = i2c_exp_pkg::ST_WACK;
			i2c_exp_pkg::ST_WACK:
				if (scl_fall)
					next_state = i2c_exp_pkg::ST_WBYT;
			i2c_exp_pkg::ST_RBYT:
				if (scl_fall && byte_done)
					next_state = i2c_exp_pkg::ST_RACK;
			i2c_exp_pkg::ST_RACK:
				if (scl_fall)
					next_state = sda_q ? i2c_exp_pkg::ST_IGN : i2c_exp_pkg::ST_RBYT;
			i2c_exp_pkg::ST_IGN:  next_state = state;
			default:              next_state = i2c_exp_pkg::ST_IDLE;
		endcase
		if (start_det)
			next_state = i2c_exp_pkg::ST_ADDR;
		else if (stop_det)
			next_state = i2c_exp_pkg::ST_IDLE;
	end

	// One asynchronous reset serves both the pin and the power-on source.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= i2c_exp_pkg::ST_IDLE;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			state <= next_state;
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	// Bit counter and shift register; sampling on rise keeps data stable while clock high.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			bit_cnt <= 4'h0;
			shreg   <= 8'h00;
			is_read <= 1'b0;
		end
		else if (start_det || (scl_fall && (state == i2c_exp_pkg::ST_WACK)))
			bit_cnt <= 4'h0;
		else if (scl_fall && (state == i2c_exp_pkg::ST_AACK || state == i2c_exp_pkg::ST_RACK))
		begin
			bit_cnt <= 4'h0;
			shreg   <= tx_data;
		end
		else if (scl_rise && !byte_done)
		begin
			bit_cnt <= bit_cnt + 4'h1;
			if (state != i2c_exp_pkg::ST_RBYT)
				shreg <= {shreg[6:0], sda_f};
		end
		else if (scl_fall && state == i2c_exp_pkg::ST_RBYT && bit_cnt != 4'h0)
			shreg <= {shreg[6:0], 1'b0};
		else if (scl_fall && state == i2c_exp_pkg::ST_ADDR && byte_done)
			is_read <= shreg[0] == i2c_exp_pkg::DIR_READ;
	end

	// Data pull-down: acknowledges and read bits change on the falling clock; a start or stop releases it.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			pull_low <= 1'b0;
		else if (start_det || stop_det)
			pull_low <= 1'b0;
		else if (scl_fall)
		begin
			case (next_state)
				i2c_exp_pkg::ST_AACK: pull_low <= 1'b1;
				i2c_exp_pkg::ST_WACK: pull_low <= 1'b1;
				i2c_exp_pkg::ST_RBYT:
					if (state == i2c_exp_pkg::ST_RBYT)
						pull_low <= !shreg[6];
					else
						pull_low <= !tx_data[7];
				default:              pull_low <= 1'b0;
			endcase
		end
	end

	// Rising clock of a read acknowledge clears the selected pending lines.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_clr     <= 1'b0;
			rx_data    <= 8'h00;
			rx_valid   <= 1'b0;
			rx_first   <= 1'b0;
			first_pend <= 1'b0;
			tx_load    <= 1'b0;
		end
		else
		begin
			rd_clr   <= scl_rise && state == i2c_exp_pkg::ST_RACK;
			rx_valid <= scl_fall && state == i2c_exp_pkg::ST_WBYT && byte_done;
			tx_load  <= scl_fall && next_state == i2c_exp_pkg::ST_RBYT &&
				state != i2c_exp_pkg::ST_RBYT;
			if (scl_fall && state == i2c_exp_pkg::ST_WBYT && byte_done)
			begin
				rx_data    <= shreg;
				rx_first   <= first_pend;
				first_pend <= 1'b0;
			end
			else if (state == i2c_exp_pkg::ST_AACK)
				first_pend <= 1'b1;
		end
	end

	// A change landing on the clearing edge is folded into the reference and may be lost.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ref_val  <= i2c_exp_pkg::ZERO18;
			int_stat <= i2c_exp_pkg::ZERO18;
		end
		else
		begin
			ref_val  <= next_ref;
			int_stat <= next_stat;
		end
	end

	// Outputs; the alert pulls low while any enabled line is pending.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sda_out     <= 1'b0;
			sda_oe_n    <= 1'b1;
			int_out     <= 1'b0;
			int_oe_n    <= 1'b1;
			pull_en     <= i2c_exp_pkg::PULL_RST;
			input_state <= i2c_exp_pkg::ZERO18;
			bus_busy    <= 1'b0;
			int_sync1   <= 1'b1;
			int_sync2   <= 1'b1;
		end
		else
		begin
			sda_out     <= 1'b0;
			sda_oe_n    <= !pull_low;
			int_out     <= 1'b0;
			int_oe_n    <= !alert;
			pull_en     <= is_input;
			input_state <= ref_val;
			bus_busy    <= state != i2c_exp_pkg::ST_IDLE;
			int_sync1   <= int_in;
			int_sync2   <= int_sync1;
		end
	end

	// Free-running tick that clocks the debounce stages.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tick_cnt <= 13'h0000;
			tick     <= 1'b0;
		end
		else
		begin
			tick_cnt <= tick_wrap ? 13'h0000 : tick_cnt + 13'h0001;
			tick     <= tick_wrap;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	a_start_addr: assert property (start_det |=> state == i2c_exp_pkg::ST_ADDR)
		else $error("start not followed by address phase");
	a_stop_idle: assert property (stop_det && !start_det |=> state == i2c_exp_pkg::ST_IDLE)
		else $error("stop did not return to idle");
	a_addr_ack: assert property (scl_fall && state == i2c_exp_pkg::ST_ADDR && byte_done
		&& addr_hit |=> ##1 !sda_oe_n)
		else $error("matching address not acknowledged");
	a_other_slave: assert property (state == i2c_exp_pkg::ST_IGN |-> ##1 sda_oe_n)
		else $error("data driven while not addressed");
	a_write_ack: assert property (rx_valid |=> !sda_oe_n)
		else $error("received byte not acknowledged");
	a_read_stable: assert property (state == i2c_exp_pkg::ST_RBYT && scl_f && scl_q
		&& !start_det && !stop_det ##1 scl_f |-> $stable(sda_oe_n))
		else $error("data changed while clock high");
	a_clear_ref: assert property (rd_clr |=> ((ref_val ^ $past(deb_val)) &
		$past(read_sel_mask)) == i2c_exp_pkg::ZERO18)
		else $error("read clear did not reload reference");
	a_out_quiet: assert property ((gpio_dir == gpio_dir)[*2] |->
		(int_stat & $past(gpio_dir)) == i2c_exp_pkg::ZERO18)
		else $error("output line raised a pending change");
	a_alert_drive: assert property (alert [*2] |-> !int_oe_n)
		else $error("alert not driven for pending change");
	a_pull_input: assert property ((gpio_dir == i2c_exp_pkg::ZERO18) [*2] |->
		pull_en == i2c_exp_pkg::PULL_RST)
		else $error("pulldown missing on input line");
	// The alert has no reader inside the block, so its wire is checked on the way back.
	a_alert_wire: assert property (!int_oe_n [*3] |-> !int_sync2)
		else $error("alert wire not seen low");
	a_nack_release: assert property (scl_fall && state == i2c_exp_pkg::ST_RACK && sda_q
		|=> ##1 sda_oe_n)
		else $error("data not released after not-acknowledge");

	c_read_xfer: cover property (rd_clr && sda_f);
	c_write_xfer: cover property (rx_valid && !rx_first);
	c_alert_clear: cover property (!int_oe_n ##[1:1000] int_oe_n);
	c_addr_miss: cover property (state == i2c_exp_pkg::ST_IGN && scl_rise);
	c_debounce_alert: cover property (debounce_en && tick && alert);
endmodule

// >>> dv/i2c_master_model.sv
// Behavioural bus master that drives the clock and data lines of the slave.
module i2c_master_model #(
	parameter int H = 16
) (
	input  wire logic clk,
	input  wire logic sda_w,
	output logic      scl,
	output logic      sda
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Data moves mid-low and is sampled at the end of the high phase.
	task automatic bit_io(input logic b, output logic r);
		tick(H / 2);
		sda <= b;
		tick(H / 2);
		scl <= 1'b1;
		tick(H);
		r = sda_w;
		scl <= 1'b0;
	endtask
	// Also a repeated start; from an idle bus the first steps change nothing.
	task automatic start();
		tick(H / 2);
		sda <= 1'b1;
		tick(H / 2);
		scl <= 1'b1;
		tick(H / 2);
		sda <= 1'b0;
		tick(H / 2);
		scl <= 1'b0;
	endtask
	task automatic stop();
		tick(H / 2);
		sda <= 1'b0;
		tick(H / 2);
		scl <= 1'b1;
		tick(H / 2);
		sda <= 1'b1;
		tick(H);
	endtask
	task automatic byte_io(input logic [7:0] d, input logic ai, output logic [7:0] q,
		output logic ao);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ai, ao);
	endtask
	task automatic glitch(input int n);
		sda <= 1'b0;
		tick(n);
		sda <= 1'b1;
	endtask
endmodule

// >>> dv/test_i2c_exp_core.sv
// Self-checking bench for the bus slave front end and change alert.
module test_i2c_exp_core;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEB = 16;
	logic        ref_clk;
	logic        resetn;
	logic [17:0] gpio_in;
	logic [17:0] gpio_dir;
	logic [17:0] gpio_int_en;
	logic        debounce_en;
	logic [17:0] read_sel_mask;
	logic [7:0]  tx_data;
	logic        sda_out;
	logic        sda_oe_n;
	logic        int_out;
	logic        int_oe_n;
	logic [17:0] pull_en;
	logic [17:0] input_state;
	logic [17:0] int_stat;
	logic [7:0]  rx_data;
	logic        rx_valid;
	logic        rx_first;
	logic        tx_load;
	logic        bus_busy;
	logic        scl;
	logic        m_sda;
	logic [8:0]  rx_got;
	logic [7:0]  q;
	logic        a;
	int          err_total;
	int          checks;
	int          tx_loads;
	wire         sda_w = m_sda & (sda_oe_n | sda_out);
	wire         int_w = int_oe_n | int_out;

	i2c_master_model m (.clk(ref_clk), .sda_w(sda_w), .scl(scl), .sda(m_sda));
	i2c_exp_core #(.DEB_TICK_CYC(DEB)) uut (
		.ref_clk(ref_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_in(int_w), .int_out(int_out),
		.int_oe_n(int_oe_n), .gpio_in(gpio_in), .gpio_dir(gpio_dir),
		.gpio_int_en(gpio_int_en), .debounce_en(debounce_en),
		.read_sel_mask(read_sel_mask), .tx_data(tx_data), .pull_en(pull_en),
		.input_state(input_state), .int_stat(int_stat), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_first(rx_first), .tx_load(tx_load), .bus_busy(bus_busy));

	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
		if (rx_valid === 1'b1)
			rx_got <= {rx_first, rx_data};
	always @(posedge ref_clk)
		if (tx_load === 1'b1)
			tx_loads <= tx_loads + 1;

	task automatic go(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_alert(input int n);
		for (int k = 0; k < n && int_w !== 1'b0; k++)
			go(1);
		chk(18'(int_w), 18'h0);
	endtask
	task automatic chk_defaults();
		chk(pull_en, i2c_exp_pkg::PULL_RST);
		chk(int_stat, i2c_exp_pkg::ZERO18);
		chk(18'({sda_oe_n, int_oe_n, bus_busy}), 18'h6);
	endtask
	task automatic t_write();
		m.start();
		m.byte_io(8'h68, 1'b1, q, a);
		chk(18'(a), 18'h0);
		chk(18'(bus_busy), 18'h1);
		m.byte_io(8'ha5, 1'b1, q, a);
		chk(18'(a), 18'h0);
		chk(18'(rx_got), 18'h1a5);
		m.byte_io(8'h3c, 1'b1, q, a);
		chk(18'(a), 18'h0);
		chk(18'(rx_got), 18'h03c);
		m.stop();
		go(12);
		chk(18'(bus_busy), 18'h0);
		$display("t_write done");
	endtask
	task automatic t_alert();
		gpio_in <= 18'h8;
		wait_alert(8);
		chk(int_stat, 18'h8);
		gpio_in <= 18'h0;
		go(8);
		chk(18'({int_stat, int_w}), 18'h1);
		gpio_dir <= 18'h10;
		go(2);
		gpio_in <= 18'h10;
		go(8);
		chk(18'({int_stat, int_w}), 18'h1);
		chk(pull_en, 18'h3ffef);
		gpio_dir <= 18'h0;
		wait_alert(8);
		chk(int_stat, 18'h10);
		gpio_in <= 18'h0;
		go(8);
		chk(18'(int_w), 18'h1);
		$display("t_alert done");
	endtask
	task automatic t_other();
		gpio_in <= 18'h8;
		read_sel_mask <= 18'h8;
		wait_alert(8);
		m.start();
		m.byte_io(8'h6b, 1'b1, q, a);
		chk(18'(a), 18'h1);
		m.byte_io(8'h00, 1'b1, q, a);
		chk(18'(a), 18'h1);
		m.stop();
		go(12);
		chk(18'({int_stat, int_w}), 18'h10);
		$display("t_other done");
	endtask
	task automatic t_read();
		tx_data <= 8'h96;
		m.start();
		m.byte_io(8'h69, 1'b1, q, a);
		chk(18'(a), 18'h0);
		chk(18'(int_w), 18'h0);
		m.byte_io(8'hff, 1'b0, q, a);
		tx_data <= 8'h5a;
		chk(18'(q), 18'h96);
		chk(18'(int_w), 18'h1);
		chk(input_state, 18'h8);
		m.byte_io(8'hff, 1'b1, q, a);
		chk(18'(q), 18'h5a);
		go(1);
		chk(18'(sda_oe_n), 18'h1);
		m.stop();
		go(12);
		chk(18'(bus_busy), 18'h0);
		chk(18'(tx_loads), 18'h2);
		gpio_in <= 18'h0;
		wait_alert(8);
		chk(int_stat, 18'h8);
		gpio_in <= 18'h8;
		go(8);
		chk(18'(int_w), 18'h1);
		$display("t_read done");
	endtask
	task automatic t_debounce();
		debounce_en <= 1'b1;
		go(4);
		gpio_in <= 18'ha;
		wait_alert(2 * DEB + 8);
		gpio_in <= 18'h8;
		go(2 * DEB + 8);
		chk(18'({int_stat, int_w}), 18'h1);
		debounce_en <= 1'b0;
		$display("t_debounce done");
	endtask
	task automatic t_misc();
		m.glitch(3);
		go(12);
		chk(18'(bus_busy), 18'h0);
		gpio_in <= 18'h0;
		gpio_dir <= 18'h1;
		wait_alert(8);
		gpio_int_en <= 18'h3fff7;
		go(4);
		chk(18'({int_stat, int_w}), 18'h11);
		gpio_int_en <= 18'h3ffff;
		resetn <= 1'b0;
		go(i2c_exp_pkg::RESET_CYC);
		chk_defaults();
		resetn <= 1'b1;
		gpio_dir <= 18'h0;
		go(i2c_exp_pkg::RESET_CYC);
		chk_defaults();
		$display("t_misc done");
	endtask
	task automatic close_out();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		err_total = 0;
		checks = 0;
		tx_loads = 0;
		resetn = 1'b0;
		gpio_in = 18'h0;
		gpio_dir = 18'h0;
		gpio_int_en = 18'h3ffff;
		debounce_en = 1'b0;
		read_sel_mask = 18'h0;
		tx_data = 8'h00;
		go(3);
		chk_defaults();
		resetn <= 1'b1;
		go(12);
		chk_defaults();
		t_write();
		t_alert();
		t_other();
		t_read();
		t_debounce();
		t_misc();
		close_out();
	end
	// Generous bound: the sequence, both long reset holds included, needs about 33000 cycles.
	initial
	begin
		go(60000);
		err_total++;
		close_out();
	end
endmodule
